// [bench/cfs_scan_unit_assertions.sv]
// Port checker for the character field scan unit
`default_nettype none
`include "cfs_consts.svh"
module cfs_scan_unit_assertions (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire logic err_o,
	// Storage and status
	input wire logic mem_req_o,
	input wire logic [`CFS_AW-1:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [5:0] mem_char_i,
	input wire logic busy_o,
	input wire logic [1:0] decimal_sign_condition_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic dir;
	logic seen;
	logic [11:0] len;
	logic [12:0] nf;
	logic [`CFS_AW-1:0] last;
	logic [1:0] hi;
	logic take;
	logic start_w;
	assign take = mem_req_o && mem_ack_i;
	assign start_w = cyc_i && stb_i && we_i && !busy_o && !ack_o && !err_o;
	// Scan mode, length and fetch history as seen at the ports
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir <= 1'h0;
			len <= 12'h000;
			seen <= 1'h0;
			nf <= 13'h0000;
			last <= 18'h0_0000;
			hi <= 2'h0;
		end else begin
			if (start_w && adr_i == `CFS_REG_CTRL && dat_i[0]) dir <= dat_i[1];
			if (start_w && adr_i == `CFS_REG_LEN) len <= dat_i[11:0];
			if (take && !seen) hi <= mem_char_i[5:4];
			if (take) last <= mem_addr_o;
			seen <= busy_o && (seen || take);
			nf <= busy_o ? nf + {12'h000, take} : 13'h0000;
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence bus_req;
		cyc_i && stb_i && !ack_o && !err_o;
	endsequence
	sequence fetch_wait;
		mem_req_o && !mem_ack_i;
	endsequence
	bus_answer_a: assert property (bus_req |=> ack_o || err_o)
		else $error("bus request not answered");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	unmapped_err_a: assert property (bus_req ##0 adr_i > 8'h24 |=> err_o && !ack_o)
		else $error("unmapped access not refused");
	fetch_hold_a: assert property (fetch_wait |=> mem_req_o && $stable(mem_addr_o))
		else $error("fetch dropped before answer");
	fetch_busy_a: assert property (mem_req_o |-> busy_o)
		else $error("fetch outside a scan");
	field_step_a: assert property ($rose(mem_req_o) && seen |->
		mem_addr_o == (dir ? last + 18'h0_0001 : last - 18'h0_0001))
		else $error("fetch address did not step by one");
	fetch_limit_a: assert property (busy_o |-> nf <= {1'h0, len})
		else $error("more characters fetched than length");
	sign_keep_a: assert property (busy_o && !dir |=> $stable(decimal_sign_condition_o))
		else $error("sign changed in left to right scan");
	sign_load_a: assert property ($fell(busy_o) && dir && seen |=>
		decimal_sign_condition_o == hi)
		else $error("sign not taken from first character");
endmodule : cfs_scan_unit_assertions
bind cfs_scan_unit cfs_scan_unit_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .dat_i, .ack_o, .err_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_char_i,
	.busy_o, .decimal_sign_condition_o);
`default_nettype wire

// [bench/cfs_scan_unit_bench.sv]
// Self-checking bench for the character field scan unit
`default_nettype none
`include "cfs_consts.svh"
module cfs_scan_unit_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc_i = 1'h0;
	logic stb_i = 1'h0;
	logic we_i = 1'h0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic ack_o;
	logic err_o;
	logic mem_req_o;
	logic [`CFS_AW-1:0] mem_addr_o;
	logic mem_ack_i;
	logic [5:0] mem_char_i;
	logic busy_o;
	logic [1:0] decimal_sign_condition_o;
	logic [3:0] lat = 4'h0;
	logic [15:0] lf = 16'h005E;
	logic [1:0] esg = 2'h0;
	int n_errors = 0;
	int checks = 0;
	cfs_scan_unit i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .err_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_char_i, .busy_o,
		.decimal_sign_condition_o);
	cfs_storage_model u_mem (.clk_i, .lat_i(lat), .req_i(mem_req_o), .addr_i(mem_addr_o),
		.ack_o(mem_ack_i), .char_o(mem_char_i));
	initial forever #12.5 clk_i = ~clk_i;
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	function automatic logic [7:0] pos(input logic [17:0] a, input logic rl, input int i);
		return rl ? 8'(a + 18'(i)) : 8'(a - 18'(i));
	endfunction : pos
	// Returns {hit, searched count on a hit, search length otherwise}
	function automatic logic [12:0] expect_scan(input logic [17:0] a, input logic rl, ne, dc,
		input logic [11:0] len, input logic [5:0] sc, dch);
		logic [5:0] c;
		logic eq;
		for (int i = 0; i < int'(len); i++) begin
			c = u_mem.mem[pos(a, rl, i)];
			eq = c == sc && !(sc == `CFS_ZERO_CHAR && c inside {`CFS_Z12, `CFS_Z32, `CFS_Z52});
			if (eq != ne) return {1'h1, 12'(i + 1)};
			if (dc && c == dch) return {1'h0, len};
		end
		return {1'h0, len};
	endfunction : expect_scan
	task chk32(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk32
	task tally_and_finish();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		sel_i <= 4'hF;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'h1 && err_o !== 1'h1);
		q = dat_o;
		e = err_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask : wb
	task automatic run_scan(input logic rl, ne, dc, input logic [1:0] ix, input logic [11:0] len,
		input logic [5:0] sc, dch, input logic [17:0] r, input logic hold);
		logic [31:0] q;
		logic e;
		logic [17:0] p;
		logic [17:0] ea;
		logic [12:0] res;
		p = {2'h0, lf};
		ea = r + (ix == 2'h0 ? 18'h0_0000 : ix == 2'h2 ? 18'h0_0009 : 18'h0_0003);
		res = expect_scan(ea, rl, ne, dc, len, sc, dch);
		if (rl && len != 12'h000) esg = u_mem.mem[ea[7:0]][5:4];
		wb(`CFS_REG_ADDR, 1'h1, {14'h0, r}, q, e);
		wb(`CFS_REG_LEN, 1'h1, {20'h0, len}, q, e);
		wb(`CFS_REG_CHARS, 1'h1, {18'h0, dch, 2'h0, sc}, q, e);
		wb(`CFS_REG_PADDR, 1'h1, {14'h0, p}, q, e);
		wb(`CFS_REG_CTRL, 1'h1, {26'h0, ix, dc, ne, rl, 1'h1}, q, e);
		if (hold) wb(`CFS_REG_LEN, 1'h1, 32'h0000_0001, q, e);
		while (busy_o !== 1'h0) begin
			@(posedge clk_i);
		end
		wb(`CFS_REG_COUNT, 1'h0, 32'h0, q, e);
		chk32({20'h0, q[11:0]}, {20'h0, res[11:0]});
		wb(`CFS_REG_NEXT, 1'h0, 32'h0, q, e);
		chk32(q, {14'h0, p + (res[12] ? 18'h0_0004 : 18'h0_0003)});
		wb(`CFS_REG_STATUS, 1'h0, 32'h0, q, e);
		chk32({28'h0, q[3:0]}, {28'h0, res[12], esg, 1'h0});
		chk32({30'h0, decimal_sign_condition_o}, {30'h0, esg});
	endtask : run_scan
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic e;
		logic [5:0] zc [0:3];
		logic [5:0] sc;
		logic [5:0] dch;
		logic [17:0] r;
		logic [11:0] len;
		logic [1:0] ix;
		logic rl, ne, dc;
		zc = '{`CFS_Z12, `CFS_Z32, `CFS_Z52, `CFS_ZERO_CHAR};
		repeat (5) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		wb(8'h30, 1'h0, 32'h0, q, e);
		chk32({q[31:1], e}, 32'h0000_0001);
		wb(`CFS_REG_IDX1, 1'h1, 32'h0000_0003, q, e);
		wb(`CFS_REG_IDX2, 1'h1, 32'h0000_0009, q, e);
		for (int k = 0; k < 30; k++) begin
			for (int i = 0; i < 256; i++) begin
				lf = nxt(lf);
				u_mem.mem[i] = {lf[5:4], 2'h0, lf[1:0]};
			end
			lf = nxt(lf);
			{rl, ne, dc, ix, lat} = {lf[4:0], 2'h0, lf[6:5]};
			len = {9'h0, lf[9:7]} + 12'h001;
			sc = {lf[11:10], 2'h0, lf[13:12]};
			dch = {lf[15:14], 2'h0, lf[1:0]};
			lf = nxt(lf);
			r = {11'h000, 7'h40 + lf[6:0]};
			if (k < 2) begin
				{rl, ne, dc, ix, sc, len} = {1'h0, k[0], 1'h0, 2'h0, 6'h00, 12'h004};
				for (int i = 0; i < 4; i++) u_mem.mem[pos(r, rl, i)] = zc[i];
			end
			if (k == 2 || k == 5) begin
				{ne, dc, ix, dch} = {1'h0, 1'h1, 2'h0, k == 2 ? sc : sc ^ 6'h01};
				u_mem.mem[pos(r, rl, 0)] = dch;
			end
			if (k == 3) len = 12'h000;
			if (k == 4) lat = 4'h9;
			run_scan(rl, ne, dc, ix, len, sc, dch, r, k == 4);
		end
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule : cfs_scan_unit_bench
`default_nettype wire

// [bench/cfs_storage_model.sv]
// Behavioural character storage for the scan unit
`default_nettype none
module cfs_storage_model (
	// Clock and pacing
	input wire logic clk_i,
	input wire logic [3:0] lat_i,
	// Fetch port
	input wire logic req_i,
	input wire logic [17:0] addr_i,
	output logic ack_o,
	output logic [5:0] char_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] mem [0:255];
	logic [3:0] wcnt = 4'h0;
	initial ack_o = 1'h0;
	initial char_o = 6'h00;
	// Answers after lat_i waiting cycles; data scrambles when not answering
	always @(posedge clk_i) begin
		ack_o <= 1'h0;
		char_o <= ~char_o;
		if (req_i && !ack_o) begin
			if (wcnt == lat_i) begin
				ack_o <= 1'h1;
				char_o <= mem[addr_i[7:0]];
				wcnt <= 4'h0;
			end else begin
				wcnt <= wcnt + 4'h1;
			end
		end
	end
endmodule : cfs_storage_model
`default_nettype wire

// [hw/cfs_char_cmp.sv]
// Character compare for one scan step
`default_nettype none
`include "cfs_consts.svh"
module cfs_char_cmp
	import cfs_pkg::*;
(
	// Operands
	input wire logic [5:0] char_i,
	input wire logic [5:0] scan_char_i,
	input wire logic [5:0] delimit_char_i,
	// Mode
	input wire logic match_unequal_i,
	input wire logic delimit_i,
	// Results
	output logic qualify_o,
	output logic delimit_hit_o
);
	function automatic logic is_zone_zero(input logic [5:0] c);
		is_zone_zero = (c == `CFS_Z12) || (c == `CFS_Z32) || (c == `CFS_Z52);
	endfunction : is_zone_zero

	logic equal;

	always_comb begin
		// Zoned zero codes never equal a zero scan character
		equal = (char_i == scan_char_i) &&
			!((scan_char_i == `CFS_ZERO_CHAR) && is_zone_zero(char_i));
		if (scan_char_i == `CFS_ZERO_CHAR && is_zone_zero(char_i))
			equal = 1'b0;
		qualify_o = match_unequal_i ? !equal : equal;
		delimit_hit_o = delimit_i && (char_i == delimit_char_i);
	end
endmodule : cfs_char_cmp
`default_nettype wire

// [hw/cfs_consts.svh]
// Constants for the character field scan unit
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH
// ---------------------------------------------------------------
// Bus register offsets (byte addresses)
// ---------------------------------------------------------------
`define CFS_REG_CTRL 8'h00
`define CFS_REG_ADDR 8'h04
`define CFS_REG_LEN 8'h08
`define CFS_REG_CHARS 8'h0C
`define CFS_REG_IDX1 8'h10
`define CFS_REG_IDX2 8'h14
`define CFS_REG_PADDR 8'h18
`define CFS_REG_STATUS 8'h1C
`define CFS_REG_COUNT 8'h20
`define CFS_REG_NEXT 8'h24
// ---------------------------------------------------------------
// Control field positions
// ---------------------------------------------------------------
`define CFS_CTRL_START 0
`define CFS_CTRL_RL 1
`define CFS_CTRL_NE 2
`define CFS_CTRL_DC 3
`define CFS_CTRL_IDX_LO 4
`define CFS_CTRL_IDX_HI 5
// ---------------------------------------------------------------
// Widths, offsets and character codes
// ---------------------------------------------------------------
`define CFS_AW 18
`define CFS_LENW 12
`define CFS_NEXT_HIT 3'h4
`define CFS_NEXT_MISS 3'h3
`define CFS_ZERO_CHAR 6'h00
`define CFS_Z12 6'h0A
`define CFS_Z32 6'h1A
`define CFS_Z52 6'h2A
`endif

// [hw/cfs_pkg.sv]
// Types for the character field scan unit
`default_nettype none
package cfs_pkg;
	typedef enum logic [2:0] {
		CFS_IDLE = 3'b000,
		CFS_REQ = 3'b001,
		CFS_WAIT = 3'b010,
		CFS_CMP = 3'b011,
		CFS_DONE = 3'b100
	} cfs_state_t;
endpackage : cfs_pkg
`default_nettype wire

// [hw/cfs_scan_unit.sv]
// Character field scan unit with Wishbone registers and storage port
// How it works
// - Left-to-right scans start at high-order char and step down in address.
// - Right-to-left scans start at low-order char and step up.
// - Effective address adds index one (flag 1,3), index two (2), none (0).
// - At most search-length characters are compared, then the scan stops.
// - Equality scan: match gives P+4, exhausted field gives P+3.
// - Inequality scan: differing char gives P+4, all equal gives P+3.
// - Delimited scan: delimiter match stops with P+3.
// - A qualifying compare beats the delimiter when both hit.
// - On success, searched count goes to low 12 bits of count register.
// - With no qualifying char the count register gets the search length.
// - Upper 3 bits of count register are undefined; written zero here.
// - Zoned zero codes 12, 32, 52 octal never equal a zero scan char.
// - In inequality scans those codes are unequal to a zero scan char.
// - Left-to-right scans keep the sign-condition register.
// - Right-to-left scans load sign condition from top 2 bits of first char.
//
// The implementer's own choices: the address map and the Wishbone slave port.
`default_nettype none
`include "cfs_consts.svh"
module cfs_scan_unit
	import cfs_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// Character storage port
	output logic mem_req_o,
	output logic [`CFS_AW-1:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [5:0] mem_char_i,
	// Status
	output logic busy_o,
	output logic [1:0] decimal_sign_condition_o
);
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic right_to_left, match_unequal, delimit_en;
	logic [1:0] idx_sel;
	logic [`CFS_AW-1:0] base_addr, idx1, idx2, p_addr, next_instruction_fetch;
	logic [`CFS_LENW-1:0] search_len;
	logic [5:0] scan_char, delimit_char;
	logic [14:0] count_reg;
	logic [1:0] decimal_sign_condition;
	logic hit;
	cfs_state_t state;
	logic [`CFS_AW-1:0] cur_addr;
	logic [`CFS_LENW-1:0] searched;
	logic [5:0] cur_char;
	logic first;
	logic ack;
	logic [31:0] rdata;

	logic next_right_to_left, next_match_unequal, next_delimit_en;
	logic [1:0] next_idx_sel;
	logic [`CFS_AW-1:0] next_base_addr, next_idx1, next_idx2, next_p_addr;
	logic [`CFS_AW-1:0] next_next_instruction_fetch, next_cur_addr;
	logic [`CFS_LENW-1:0] next_search_len, next_searched;
	logic [5:0] next_scan_char, next_delimit_char, next_cur_char;
	logic [14:0] next_count_reg;
	logic [1:0] next_decimal_sign_condition;
	logic next_hit, next_first, next_ack;
	cfs_state_t next_state;
	logic [31:0] next_rdata;

	logic qualify, delimit_hit, bus_req, wr, start, mapped;
	logic [31:0] wold, wmerged;
	logic [`CFS_AW-1:0] eff_addr;

	cfs_char_cmp u_cmp (
		.char_i(cur_char),
		.scan_char_i(scan_char),
		.delimit_char_i(delimit_char),
		.match_unequal_i(match_unequal),
		.delimit_i(delimit_en),
		.qualify_o(qualify),
		.delimit_hit_o(delimit_hit)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	always_comb begin
		bus_req = cyc_i && stb_i && !ack;
		wr = bus_req && we_i && (state == CFS_IDLE);
		case (adr_i)
			`CFS_REG_CTRL, `CFS_REG_ADDR, `CFS_REG_LEN, `CFS_REG_CHARS,
			`CFS_REG_IDX1, `CFS_REG_IDX2, `CFS_REG_PADDR, `CFS_REG_STATUS,
			`CFS_REG_COUNT, `CFS_REG_NEXT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
		case (adr_i)
			`CFS_REG_ADDR: wold = {14'h0, base_addr};
			`CFS_REG_LEN: wold = {20'h0, search_len};
			`CFS_REG_CHARS: wold = {18'h0, delimit_char, 2'h0, scan_char};
			`CFS_REG_IDX1: wold = {14'h0, idx1};
			`CFS_REG_IDX2: wold = {14'h0, idx2};
			`CFS_REG_PADDR: wold = {14'h0, p_addr};
			default: wold = 32'h0000_0000;
		endcase
		wmerged = merge(wold, dat_i, sel_i);
		start = wr && (adr_i == `CFS_REG_CTRL) && sel_i[0] && dat_i[`CFS_CTRL_START];
		// Index select of the starting control word, not the stale one
		case (wmerged[`CFS_CTRL_IDX_HI:`CFS_CTRL_IDX_LO])
			2'd1, 2'd3: eff_addr = base_addr + idx1;
			2'd2: eff_addr = base_addr + idx2;
			default: eff_addr = base_addr;
		endcase
	end

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		next_right_to_left = right_to_left;
		next_match_unequal = match_unequal;
		next_delimit_en = delimit_en;
		next_idx_sel = idx_sel;
		next_base_addr = base_addr;
		next_idx1 = idx1;
		next_idx2 = idx2;
		next_p_addr = p_addr;
		next_search_len = search_len;
		next_scan_char = scan_char;
		next_delimit_char = delimit_char;
		next_count_reg = count_reg;
		next_decimal_sign_condition = decimal_sign_condition;
		next_next_instruction_fetch = next_instruction_fetch;
		next_hit = hit;
		next_state = state;
		next_cur_addr = cur_addr;
		next_searched = searched;
		next_cur_char = cur_char;
		next_first = first;
		next_ack = bus_req;
		next_rdata = 32'h0000_0000;
		if (wr) begin
			case (adr_i)
				`CFS_REG_CTRL: begin
					next_right_to_left = wmerged[`CFS_CTRL_RL];
					next_match_unequal = wmerged[`CFS_CTRL_NE];
					next_delimit_en = wmerged[`CFS_CTRL_DC];
					next_idx_sel = wmerged[`CFS_CTRL_IDX_HI:`CFS_CTRL_IDX_LO];
				end
				`CFS_REG_ADDR: next_base_addr = wmerged[17:0];
				`CFS_REG_LEN: next_search_len = wmerged[11:0];
				`CFS_REG_CHARS: begin
					next_scan_char = wmerged[5:0];
					next_delimit_char = wmerged[13:8];
				end
				`CFS_REG_IDX1: next_idx1 = wmerged[17:0];
				`CFS_REG_IDX2: next_idx2 = wmerged[17:0];
				`CFS_REG_PADDR: next_p_addr = wmerged[17:0];
				default: ;
			endcase
		end
		if (bus_req && !we_i) begin
			case (adr_i)
				`CFS_REG_CTRL: next_rdata = {26'h0, idx_sel, delimit_en, match_unequal,
					right_to_left, 1'b0};
				`CFS_REG_ADDR: next_rdata = {14'h0, base_addr};
				`CFS_REG_LEN: next_rdata = {20'h0, search_len};
				`CFS_REG_CHARS: next_rdata = {18'h0, delimit_char, 2'h0, scan_char};
				`CFS_REG_IDX1: next_rdata = {14'h0, idx1};
				`CFS_REG_IDX2: next_rdata = {14'h0, idx2};
				`CFS_REG_PADDR: next_rdata = {14'h0, p_addr};
				`CFS_REG_STATUS: next_rdata = {28'h0, hit, decimal_sign_condition,
					state != CFS_IDLE};
				`CFS_REG_COUNT: next_rdata = {17'h0, count_reg};
				`CFS_REG_NEXT: next_rdata = {14'h0, next_instruction_fetch};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		case (state)
			CFS_IDLE: begin
				if (start) begin
					// A zero length ends at once as a miss
					next_state = (search_len == 12'h000) ? CFS_DONE : CFS_REQ;
					next_cur_addr = eff_addr;
					next_searched = 12'h000;
					next_first = 1'b1;
					next_hit = 1'b0;
				end
			end
			CFS_REQ: next_state = CFS_WAIT;
			CFS_WAIT: begin
				if (mem_ack_i) begin
					next_cur_char = mem_char_i;
					next_state = CFS_CMP;
				end
			end
			CFS_CMP: begin
				next_searched = searched + 12'h001;
				next_first = 1'b0;
				if (first && right_to_left)
					next_decimal_sign_condition = cur_char[5:4];
				if (qualify) begin
					next_hit = 1'b1;
					next_state = CFS_DONE;
				end else if (delimit_hit) begin
					next_state = CFS_DONE;
				end else if (searched + 12'h001 == search_len) begin
					next_state = CFS_DONE;
				end else begin
					next_state = CFS_REQ;
					next_cur_addr = right_to_left ? cur_addr + 18'h00001
						: cur_addr - 18'h00001;
				end
			end
			CFS_DONE: begin
				next_state = CFS_IDLE;
				if (hit) begin
					next_count_reg = {3'h0, searched};
					next_next_instruction_fetch = p_addr + {15'h0, `CFS_NEXT_HIT};
				end else begin
					next_count_reg = {3'h0, search_len};
					next_next_instruction_fetch = p_addr + {15'h0, `CFS_NEXT_MISS};
				end
			end
			default: next_state = CFS_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			right_to_left <= 1'b0;
			match_unequal <= 1'b0;
			delimit_en <= 1'b0;
			idx_sel <= 2'h0;
			base_addr <= 18'h0_0000;
			idx1 <= 18'h0_0000;
			idx2 <= 18'h0_0000;
			p_addr <= 18'h0_0000;
			search_len <= 12'h000;
			scan_char <= 6'h00;
			delimit_char <= 6'h00;
			count_reg <= 15'h0000;
			decimal_sign_condition <= 2'h0;
			next_instruction_fetch <= 18'h0_0000;
			hit <= 1'b0;
			state <= CFS_IDLE;
			cur_addr <= 18'h0_0000;
			searched <= 12'h000;
			cur_char <= 6'h00;
			first <= 1'b0;
			ack <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			right_to_left <= next_right_to_left;
			match_unequal <= next_match_unequal;
			delimit_en <= next_delimit_en;
			idx_sel <= next_idx_sel;
			base_addr <= next_base_addr;
			idx1 <= next_idx1;
			idx2 <= next_idx2;
			p_addr <= next_p_addr;
			search_len <= next_search_len;
			scan_char <= next_scan_char;
			delimit_char <= next_delimit_char;
			count_reg <= next_count_reg;
			decimal_sign_condition <= next_decimal_sign_condition;
			next_instruction_fetch <= next_next_instruction_fetch;
			hit <= next_hit;
			state <= next_state;
			cur_addr <= next_cur_addr;
			searched <= next_searched;
			cur_char <= next_cur_char;
			first <= next_first;
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	logic err_q;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			err_q <= 1'b0;
		else
			err_q <= bus_req && !mapped;
	end

	always_comb begin
		ack_o = ack && !err_q;
		err_o = err_q;
		dat_o = rdata;
		mem_req_o = (state == CFS_REQ) || (state == CFS_WAIT);
		mem_addr_o = cur_addr;
		busy_o = state != CFS_IDLE;
		decimal_sign_condition_o = decimal_sign_condition;
	end
endmodule : cfs_scan_unit
`default_nettype wire
